//--- hw/srao_top.sv
// Local reset control and lowest address pin override for the memory controller
// Notes on behaviour
// - Reset control register is write-only; bits 31..30 select a local reset pulse.
// - The local reset pulse resets the memory controller logic and nothing else.
// - Selector value 00 leaves the controller alone, no pulse.
// - Selector 01 or 10 gives a reset pulse of exactly one clock.
// - Selector 11 gives a reset pulse of exactly two clocks.
// - Reserved bits of both registers read back as zero.
// - Override enable at bit 31 picks replacement bit or multiplexer for the pin.
// - Replacement bit at bit 0 is read/write and drives the pin when enabled.
// - Without override the muxed low bit is zero on 16-bit port reads.
// - Enabled override replaces the muxed low bit, configuration reads included.
// - Any controller reset returns the controller state to idle.
// - Unless boot source, reset leaves controller disabled, clocks stopped, until enabled.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "srao_defs.svh"
module srao_top (
	input  wire logic               i_sys_clk,
	input  wire logic               i_nrst,
	input  wire srao_pkg::srao_word_t i_addr,
	input  wire srao_pkg::srao_word_t i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output srao_pkg::srao_word_t    o_rdata,
	input  wire logic               i_mux_addr0,
	input  wire logic               i_port16,
	input  wire logic               i_access_rd,
	input  wire logic               i_boot_src,
	input  wire logic               i_enable_req,
	input  wire logic               i_access_req,
	input  wire logic               i_access_done,
	output logic                    o_lowest_muxed_address_pin,
	output logic                    o_controller_reset,
	output logic                    o_ctrl_clk_en,
	output logic                    o_ctrl_idle
);
	import srao_pkg::*;

	// Override register and controller state
	logic        ovr_en_r;
	logic        repl_r;
	srao_state_t state_r;
	srao_state_t state_nxt;

	// Decoded bus accesses
	logic        hit_ovr_w;
	logic        hit_rst_w;
	logic        hit_stat_w;
	logic        wr_ovr_w;
	logic        wr_rst_w;
	srao_word_t  rdata_nxt;
	srao_word_t  ovr_rd_w;
	srao_word_t  stat_rd_w;

	// Reset of the controller logic, either source
	logic        ctl_rst_w;
	logic        boot_sync_w;
	logic        pin_nxt;
	logic        mux_bit_w;

	// Helper for the pulse length check; drives nothing outside
	logic [1:0]  pulse_run_r;

	// Address decode on the full byte address; no byte lanes on this port
	assign hit_ovr_w  = (i_addr == `SRAO_ADDR_OVR_OFS);
	assign hit_rst_w  = (i_addr == `SRAO_RST_CTL_OFS);
	assign hit_stat_w = (i_addr == `SRAO_STATUS_OFS);
	assign wr_ovr_w   = i_wr && hit_ovr_w;
	assign wr_rst_w   = i_wr && hit_rst_w;

	// Boot strap is a pin and is synchronised before use
	srao_sync2 u_boot_sync (
		.i_clk   (i_sys_clk),
		.i_async (i_boot_src),
		.o_sync  (boot_sync_w)
	);

	// Only the selector field reaches the pulse generator; other bits are dropped
	srao_pulse_gen u_pulse (
		.i_clk   (i_sys_clk),
		.i_nrst  (i_nrst),
		.i_wr    (wr_rst_w),
		.i_sel   (i_wdata[`SRAO_PULSE_SEL_HI:`SRAO_PULSE_SEL_LO]),
		.o_pulse (o_controller_reset)
	);

	// Local pulse and system reset hit the same controller logic
	assign ctl_rst_w = !i_nrst || o_controller_reset;

	// Read values; reserved bits are constant zero
	assign ovr_rd_w = {ovr_en_r, 30'h0000_0000, repl_r};
	assign stat_rd_w = {29'h0000_0000, o_controller_reset, o_ctrl_idle, o_ctrl_clk_en};
	// The reset control register is write-only and reads as zero
	assign rdata_nxt = !i_rd      ? `SRAO_RDATA_RST :
	                   hit_ovr_w  ? ovr_rd_w :
	                   hit_stat_w ? stat_rd_w : `SRAO_RDATA_RST;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_rdata <= `SRAO_RDATA_RST;
		end else begin
			o_rdata <= rdata_nxt;
		end
	end

	// Override register; the local reset clears it as part of the controller
	always_ff @(posedge i_sys_clk) begin
		if (ctl_rst_w) begin
			ovr_en_r <= 1'b0;
			repl_r   <= 1'b0;
		end else if (wr_ovr_w) begin
			ovr_en_r <= i_wdata[`SRAO_OVR_EN_BIT];
			repl_r   <= i_wdata[`SRAO_OVR_REPL_BIT];
		end
	end

	// Multiplexer low bit: a 16-bit port never presents an odd address on reads
	assign mux_bit_w = (i_port16 && i_access_rd) ? 1'b0 : i_mux_addr0;
	// Override wins over the multiplexer, configuration reads included
	assign pin_nxt = ovr_en_r ? repl_r : mux_bit_w;

	// Pin is registered so it lines up with the other address pins
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_lowest_muxed_address_pin <= 1'b0;
		end else begin
			o_lowest_muxed_address_pin <= pin_nxt;
		end
	end

	// Controller activity; a new access cannot start until the previous one ends
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SRAO_ST_OFF: begin
				if (i_enable_req) begin
					state_nxt = SRAO_ST_IDLE;
				end
			end
			SRAO_ST_IDLE: begin
				if (i_access_req) begin
					state_nxt = SRAO_ST_BUSY;
				end
			end
			SRAO_ST_BUSY: begin
				if (i_access_done) begin
					state_nxt = SRAO_ST_IDLE;
				end
			end
			default: begin
				state_nxt = SRAO_ST_OFF;
			end
		endcase
	end

	// Any reset parks the controller; a boot source comes out enabled
	always_ff @(posedge i_sys_clk) begin
		if (ctl_rst_w) begin
			state_r       <= boot_sync_w ? SRAO_ST_IDLE : SRAO_ST_OFF;
			o_ctrl_clk_en <= boot_sync_w;
			o_ctrl_idle   <= 1'b1;
		end else begin
			state_r       <= state_nxt;
			o_ctrl_clk_en <= (state_nxt != SRAO_ST_OFF);
			o_ctrl_idle   <= (state_nxt != SRAO_ST_BUSY);
		end
	end

	// Checks on the register file, the pin and the controller state
	default clocking cb_sys @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);

	sequence s_rd_rst_reg;
		i_rd && hit_rst_w;
	endsequence
	sequence s_rd_ovr_reg;
		i_rd && hit_ovr_w;
	endsequence

	a_rst_reg_reads_zero: assert property (
		s_rd_rst_reg |=> (o_rdata == 32'h0000_0000))
		else $error("reset control register read not zero");
	a_ovr_reserved_zero: assert property (
		s_rd_ovr_reg |=> (o_rdata[30:1] == 30'h0000_0000))
		else $error("override register reserved bits not zero");
	a_ovr_readback: assert property (
		(wr_ovr_w && !o_controller_reset) ##1 s_rd_ovr_reg
		|=> (o_rdata[31] == $past(i_wdata[31], 2)) && (o_rdata[0] == $past(i_wdata[0], 2)))
		else $error("override register does not read back");
	a_pin_forced: assert property (
		ovr_en_r |=> (o_lowest_muxed_address_pin == $past(repl_r)))
		else $error("override bit not driven on pin");
	a_pin_rd16_zero: assert property (
		(!ovr_en_r && i_port16 && i_access_rd) |=> !o_lowest_muxed_address_pin)
		else $error("low address pin set on 16-bit read");
	a_pin_mux_pass: assert property (
		(!ovr_en_r && !(i_port16 && i_access_rd))
		|=> (o_lowest_muxed_address_pin == $past(i_mux_addr0)))
		else $error("multiplexer bit not passed to pin");
	a_regs_sys_reset: assert property (@(posedge i_sys_clk) disable iff (1'b0)
		!i_nrst |=> (!ovr_en_r && !repl_r && !o_controller_reset && (o_rdata == 32'h0)))
		else $error("registers not zero after reset");
	a_local_rst_clears: assert property (
		o_controller_reset |=> (!ovr_en_r && !repl_r))
		else $error("local reset left override set");
	a_reset_to_idle: assert property (
		o_controller_reset |=> o_ctrl_idle)
		else $error("controller not idle after local reset");
	a_reset_disables: assert property (
		(o_controller_reset && !boot_sync_w) |=> (!o_ctrl_clk_en && o_ctrl_idle))
		else $error("controller enabled after reset without boot");
	a_off_until_enable: assert property (
		(!o_ctrl_clk_en && !i_enable_req && !o_controller_reset) |=> !o_ctrl_clk_en)
		else $error("controller left disabled state without enable");
	a_enable_wakes: assert property (
		(!o_ctrl_clk_en && i_enable_req && !o_controller_reset) |=> (o_ctrl_clk_en && o_ctrl_idle))
		else $error("enable request did not start clocks");

	// Bus side: data is zero outside a read, status mirrors the controller
	sequence s_rd_stat_reg;
		i_rd && hit_stat_w;
	endsequence
	sequence s_rd_unmapped;
		i_rd && !hit_ovr_w && !hit_stat_w;
	endsequence

	a_rdata_idle_zero: assert property (
		!i_rd |=> (o_rdata == 32'h0000_0000))
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (
		s_rd_unmapped |=> (o_rdata == 32'h0000_0000))
		else $error("unmapped or write-only read not zero");
	a_stat_readback: assert property (
		s_rd_stat_reg |=> (o_rdata == {29'h0000_0000, $past(o_controller_reset),
			$past(o_ctrl_idle), $past(o_ctrl_clk_en)}))
		else $error("status word does not match controller state");

	// Override register: a live write lands, nothing but a write or a controller reset moves it
	sequence s_wr_ovr_live;
		wr_ovr_w && !ctl_rst_w;
	endsequence

	a_ovr_write_lands: assert property (
		s_wr_ovr_live |=> ((ovr_en_r == $past(i_wdata[31])) && (repl_r == $past(i_wdata[0]))))
		else $error("override write did not land");
	a_ovr_holds: assert property (
		(!wr_ovr_w && !ctl_rst_w) |=> ($stable(ovr_en_r) && $stable(repl_r)))
		else $error("override register changed without a write");

	// No disable here: this check is about the reset itself
	a_pin_sys_reset: assert property (@(posedge i_sys_clk) disable iff (1'b0)
		!i_nrst |=> (!o_lowest_muxed_address_pin && o_ctrl_idle))
		else $error("pin or controller state wrong after reset");

	// Controller state: one-hot, stays put unless asked, outputs agree with it
	a_state_onehot: assert property (
		$onehot(state_r))
		else $error("controller state not one-hot");
	a_off_clocks_stopped: assert property (
		(state_r == SRAO_ST_OFF) |-> (!o_ctrl_clk_en && o_ctrl_idle))
		else $error("disabled controller has clocks running");
	a_idle_holds: assert property (
		((state_r == SRAO_ST_IDLE) && !i_access_req && !ctl_rst_w)
		|=> (o_ctrl_idle && o_ctrl_clk_en))
		else $error("controller left idle without a request");
	a_access_starts: assert property (
		((state_r == SRAO_ST_IDLE) && i_access_req && !ctl_rst_w) |=> !o_ctrl_idle)
		else $error("access request did not leave idle");
	a_busy_until_done: assert property (
		(!o_ctrl_idle && !i_access_done && !ctl_rst_w) |=> !o_ctrl_idle)
		else $error("controller left busy without done");
	a_done_to_idle: assert property (
		(!o_ctrl_idle && i_access_done && !ctl_rst_w) |=> (o_ctrl_idle && o_ctrl_clk_en))
		else $error("controller not idle after done");
	a_boot_reset_enabled: assert property (
		(o_controller_reset && boot_sync_w) |=> (o_ctrl_clk_en && o_ctrl_idle))
		else $error("boot source not enabled after local reset");

	// A pulse may only start from a write with a non-zero selector
	a_pulse_needs_write: assert property (
		$rose(o_controller_reset) |->
			$past(wr_rst_w && (i_wdata[`SRAO_PULSE_SEL_HI:`SRAO_PULSE_SEL_LO] != `SRAO_SEL_NONE)))
		else $error("reset pulse without a selector write");

	// Count of consecutive pulse cycles; saturates so a held pulse cannot wrap
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst || !o_controller_reset) begin
			pulse_run_r <= 2'h0;
		end else if (pulse_run_r != 2'h3) begin
			pulse_run_r <= pulse_run_r + 2'h1;
		end
	end

	// A third pulse cycle needs a fresh write in the last two cycles
	a_pulse_max_two: assert property (
		(o_controller_reset && (pulse_run_r >= 2'h2)) |-> ($past(wr_rst_w) || $past(wr_rst_w, 2)))
		else $error("reset pulse longer than its selector");
endmodule

//--- shared/srao_defs.svh
// Register offsets, field positions, reset values and pulse lengths
`ifndef SRAO_DEFS_SVH
`define SRAO_DEFS_SVH

// Byte addresses of the registers
`define SRAO_ADDR_OVR_OFS     32'h0022_1014
`define SRAO_RST_CTL_OFS      32'h0022_1018
`define SRAO_STATUS_OFS       32'h0022_101c

// Local reset pulse selector field
`define SRAO_PULSE_SEL_HI     31
`define SRAO_PULSE_SEL_LO     30

// Address override fields
`define SRAO_OVR_EN_BIT       31
`define SRAO_OVR_REPL_BIT     0

// Status fields
`define SRAO_STAT_CLK_EN_BIT  0
`define SRAO_STAT_IDLE_BIT    1
`define SRAO_STAT_RST_BIT     2

// Reset values
`define SRAO_ADDR_OVR_RST     32'h0000_0000
`define SRAO_RST_CTL_RST      32'h0000_0000
`define SRAO_RDATA_RST        32'h0000_0000

// Pulse selector codes and pulse lengths in bus clock cycles
`define SRAO_SEL_NONE         2'h0
`define SRAO_SEL_ONE_A        2'h1
`define SRAO_SEL_ONE_B        2'h2
`define SRAO_SEL_TWO          2'h3
`define SRAO_PULSE_SHORT      2'h1
`define SRAO_PULSE_LONG       2'h2

`endif

//--- shared/srao_pkg.sv
// Types shared by the reset and address override block
package srao_pkg;

	typedef logic [31:0] srao_word_t;
	typedef logic [1:0]  srao_pulse_sel_t;

	// Controller activity: disabled with clocks stopped, idle, or serving an access
	typedef enum logic [2:0] {
		SRAO_ST_OFF  = 3'b001,
		SRAO_ST_IDLE = 3'b010,
		SRAO_ST_BUSY = 3'b100
	} srao_state_t;

endpackage

//--- hw/srao_sync2.sv
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module srao_sync2 (
	input  wire logic i_clk,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_r;

	// No reset: a strap must be seen while reset is still held
	always_ff @(posedge i_clk) begin
		meta_r <= i_async;
		o_sync <= meta_r;
	end
endmodule

//--- hw/srao_pulse_gen.sv
// Local reset pulse generator driven by writes of the pulse selector
`timescale 1ns/1ps
`include "srao_defs.svh"
module srao_pulse_gen (
	input  wire logic                    i_clk,
	input  wire logic                    i_nrst,
	input  wire logic                    i_wr,
	input  wire srao_pkg::srao_pulse_sel_t i_sel,
	output logic                         o_pulse
);
	import srao_pkg::*;

	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic [1:0] len_w;

	// Selector holds nothing; it only loads the countdown
	assign len_w = (i_sel == `SRAO_SEL_TWO) ? `SRAO_PULSE_LONG :
	               (i_sel == `SRAO_SEL_NONE) ? 2'h0 : `SRAO_PULSE_SHORT;
	// A new write restarts the count; otherwise it runs down to zero
	assign cnt_nxt = i_wr ? len_w : ((cnt_r != 2'h0) ? (cnt_r - 2'h1) : 2'h0);

	// Pulse comes from its own flop to keep the reset net glitch free
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cnt_r   <= 2'h0;
			o_pulse <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			o_pulse <= (cnt_nxt != 2'h0);
		end
	end

	sequence s_short_req;
		i_wr && ((i_sel == `SRAO_SEL_ONE_A) || (i_sel == `SRAO_SEL_ONE_B));
	endsequence
	sequence s_long_req;
		i_wr && (i_sel == `SRAO_SEL_TWO);
	endsequence

	a_zero_sel_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_wr && (i_sel == `SRAO_SEL_NONE)) |=> !o_pulse)
		else $error("selector 00 made a reset pulse");
	a_short_pulse_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
		s_short_req ##1 !i_wr |-> o_pulse ##1 !o_pulse)
		else $error("short reset pulse not one cycle");
	a_long_pulse_on: assert property (@(posedge i_clk) disable iff (!i_nrst)
		s_long_req |=> o_pulse [*2])
		else $error("long reset pulse shorter than two cycles");
	a_long_pulse_end: assert property (@(posedge i_clk) disable iff (!i_nrst)
		s_long_req ##1 (!i_wr) [*2] |=> !o_pulse)
		else $error("long reset pulse longer than two cycles");
	a_pulse_self_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(!i_wr) [*2] |=> !o_pulse)
		else $error("reset request stayed active");
endmodule

//--- sim/srao_flash_model.sv
// Behavioural flash device that latches the lowest address pin on each read command
`timescale 1ns/1ps
module srao_flash_model (
	input  wire logic i_clk,
	input  wire logic i_pin,
	input  wire logic i_rd_cmd,
	output logic      o_addr0
);
	// The device only looks at the pin in a read command cycle, so stale values stay hidden
	initial o_addr0 = 1'b0;
	always @(posedge i_clk) begin
		if (i_rd_cmd) begin
			o_addr0 <= i_pin;
		end
	end
endmodule

//--- sim/testbench.sv
// Register, pin override, local reset pulse and controller state tests
`timescale 1ns/1ps
`include "srao_defs.svh"
module testbench;
	import srao_pkg::*;
	logic       i_sys_clk, i_nrst, i_wr, i_rd, i_mux_addr0, i_port16, i_access_rd;
	logic       i_boot_src, i_enable_req, i_access_req, i_access_done;
	srao_word_t i_addr, i_wdata, o_rdata;
	logic       o_pin, o_controller_reset, o_ctrl_clk_en, o_ctrl_idle, dev_addr0;
	int         miscompares, num_checks, cycles, n;

	srao_top u_srao_top (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_mux_addr0(i_mux_addr0), .i_port16(i_port16), .i_access_rd(i_access_rd),
		.i_boot_src(i_boot_src), .i_enable_req(i_enable_req), .i_access_req(i_access_req),
		.i_access_done(i_access_done), .o_lowest_muxed_address_pin(o_pin),
		.o_controller_reset(o_controller_reset), .o_ctrl_clk_en(o_ctrl_clk_en),
		.o_ctrl_idle(o_ctrl_idle));
	srao_flash_model u_srao_flash_model (.i_clk(i_sys_clk), .i_pin(o_pin),
		.i_rd_cmd(i_access_rd), .o_addr0(dev_addr0));

	// Free-running bus clock, 20 ns period
	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	task automatic print_verdict;
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk_word(input srao_word_t got, input srao_word_t exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask

	// One-cycle bus strobes, changed only just after a rising edge
	task automatic wr(input srao_word_t a, input srao_word_t d);
		@(posedge i_sys_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr    <= 1'b0;
	endtask

	// Read data is looked at only in the cycle after the strobe
	task automatic rd(input srao_word_t a, input srao_word_t exp);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_sys_clk);
		i_rd   <= 1'b0;
		#1 chk_word(o_rdata, exp);
	endtask

	// Pin sources, then let the registered pin settle before comparing
	task automatic pin(input logic mux, input logic p16, input logic ard, input logic exp);
		@(posedge i_sys_clk);
		{i_mux_addr0, i_port16, i_access_rd} <= {mux, p16, ard};
		repeat (2) @(posedge i_sys_clk);
		#1 chk_bit(o_pin, exp);
	endtask

	// Controller request lines held one cycle, then two cycles to settle
	task automatic pulse_req(input logic en, input logic acc, input logic done);
		@(posedge i_sys_clk);
		{i_enable_req, i_access_req, i_access_done} <= {en, acc, done};
		@(posedge i_sys_clk);
		{i_enable_req, i_access_req, i_access_done} <= 3'h0;
		repeat (2) @(posedge i_sys_clk);
	endtask

	// Hang guard: the whole sequence needs well under 1000 cycles
	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		{i_nrst, i_wr, i_rd, i_mux_addr0, i_port16, i_access_rd} = '0;
		{i_boot_src, i_enable_req, i_access_req, i_access_done} = '0;
		i_addr = 32'h0;
		i_wdata = 32'h0;
		miscompares = 0;
		num_checks = 0;
		cycles = 0;
		repeat (5) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		rd(`SRAO_ADDR_OVR_OFS, 32'h0);
		chk_bit(o_controller_reset, 1'b0);
		chk_bit(o_ctrl_clk_en, 1'b0);
		wr(`SRAO_ADDR_OVR_OFS, 32'hffff_ffff);
		rd(`SRAO_ADDR_OVR_OFS, 32'h8000_0001);
		rd(32'h0022_1010, 32'h0);
		pin(1'b0, 1'b0, 1'b0, 1'b1);
		wr(`SRAO_ADDR_OVR_OFS, 32'h8000_0000);
		pin(1'b1, 1'b1, 1'b1, 1'b0);
		wr(`SRAO_ADDR_OVR_OFS, 32'h0);
		pin(1'b1, 1'b0, 1'b1, 1'b1);
		pin(1'b1, 1'b1, 1'b1, 1'b0);
		pin(1'b1, 1'b1, 1'b0, 1'b1);
		// Device configuration read of odd address needs the forced pin
		wr(`SRAO_ADDR_OVR_OFS, 32'h8000_0001);
		pin(1'b0, 1'b1, 1'b1, 1'b1);
		chk_bit(dev_addr0, 1'b1);
		wr(`SRAO_ADDR_OVR_OFS, 32'h0);
		pin(1'b1, 1'b1, 1'b1, 1'b0);
		chk_bit(dev_addr0, 1'b0);
		pulse_req(1'b1, 1'b0, 1'b0);
		pulse_req(1'b0, 1'b1, 1'b0);
		rd(`SRAO_STATUS_OFS, 32'h1);
		// Every selector code: pulse length, what it clears, state it leaves
		for (int s = 0; s < 4; s++) begin
			wr(`SRAO_ADDR_OVR_OFS, 32'h8000_0001);
			wr(`SRAO_RST_CTL_OFS, {s[1:0], 30'h3fff_ffff});
			n = 0;
			repeat (6) begin
				#1 n += int'(o_controller_reset === 1'b1);
				@(posedge i_sys_clk);
			end
			chk_word(n, (s == 0) ? 0 : (s == 3) ? 2 : 1);
			rd(`SRAO_RST_CTL_OFS, 32'h0);
			rd(`SRAO_ADDR_OVR_OFS, (s == 0) ? 32'h8000_0001 : 32'h0);
			chk_bit(o_ctrl_idle, s != 0);
			chk_bit(o_ctrl_clk_en, s == 0);
		end
		// Strap high: a local reset leaves the controller enabled and idle
		@(posedge i_sys_clk);
		i_boot_src <= 1'b1;
		wr(`SRAO_RST_CTL_OFS, 32'hc000_0000);
		repeat (3) @(posedge i_sys_clk);
		#1 chk_bit(o_ctrl_clk_en, 1'b1);
		chk_bit(o_ctrl_idle, 1'b1);
		pulse_req(1'b0, 1'b1, 1'b0);
		#1 chk_bit(o_ctrl_idle, 1'b0);
		pulse_req(1'b0, 1'b0, 1'b1);
		#1 chk_bit(o_ctrl_idle, 1'b1);
		pulse_req(1'b0, 1'b1, 1'b0);
		wr(`SRAO_ADDR_OVR_OFS, 32'h8000_0001);
		// System reset in mid-run with the strap low
		@(posedge i_sys_clk);
		i_nrst     <= 1'b0;
		i_boot_src <= 1'b0;
		repeat (5) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		@(posedge i_sys_clk);
		#1 chk_bit(o_ctrl_idle, 1'b1);
		chk_bit(o_ctrl_clk_en, 1'b0);
		chk_bit(o_pin, 1'b0);
		rd(`SRAO_ADDR_OVR_OFS, 32'h0);
		print_verdict();
	end
endmodule
